// File: rtl/ssp_map.svh
// register offsets, field positions and timing counts of the serial port
`ifndef SSP_MAP_SVH
`define SSP_MAP_SVH
`define SSP_CLK_MHZ       100
`define SSP_F_SCLK_MHZ    1
`define SSP_REG_STAT      7'h02
`define SSP_REG_PWR       7'h0d
`define SSP_REG_RST       7'h3a
`define SSP_PWR_RESET     8'h00
`define SSP_DIR_BIT       7
`define SSP_PD_BIT        1
`define SSP_RM_LO         2
`define SSP_APB_CMD       8'h00
`define SSP_APB_STAT      8'h04
`define SSP_CMD_WR_BIT    15
`define SSP_CMD_REC_BIT   16
`define SSP_T_MOT_RST_MS  50
`define SSP_T_REST_S      1
`define SSP_T_PD_MS       50
`define SSP_T_WAKE_MS     55
`define SSP_T_QUIET_MS    50
`define SSP_T_WW_US       30
`define SSP_T_WR_US       20
`define SSP_T_RR_NS       250
`define SSP_T_SRAD_US     4
`define SSP_CYC_US(t)     ((t) * `SSP_CLK_MHZ)
`define SSP_CYC_MS(t)     ((t) * 1000 * `SSP_CLK_MHZ)
`define SSP_CYC_S(t)      ((t) * 1000000 * `SSP_CLK_MHZ)
`define SSP_CYC_NS_UP(t)  (((t) * `SSP_CLK_MHZ + 999) / 1000)
`define SSP_HALF_CYC      (`SSP_CLK_MHZ / (2 * `SSP_F_SCLK_MHZ))
`endif

// File: rtl/ssp_pkg.sv
// state types of both ends of the serial port
`default_nettype none
package ssp_pkg;
  typedef enum {H_IDLE, H_GAP, H_LOW, H_HIGH, H_HOLD} ssp_host_state_t;
  typedef enum {D_ACTIVE, D_RST_WAIT, D_REST_IN, D_REST, D_REST_OUT, D_PD_IN, D_PD,
                D_WAKE} ssp_dev_state_t;
endpackage
`default_nettype wire

// File: rtl/ssp_if.sv
// two-wire link between host and sensor
`timescale 1ns/10ps
`default_nettype none
interface ssp_if;
  logic sclk;
  logic host_sdo;
  logic host_sdo_oe_n;
  logic dev_sdo;
  logic dev_sdo_oe_n;
  logic sdio;
  // pulled high when nobody drives
  assign sdio = !host_sdo_oe_n ? host_sdo : (!dev_sdo_oe_n ? dev_sdo : 1'b1);
  modport host (output sclk, host_sdo, host_sdo_oe_n, input sdio);
  modport dev  (input sclk, sdio, output dev_sdo, dev_sdo_oe_n);
endinterface
`default_nettype wire

// File: rtl/ssp_sync3.sv
// three-stage level synchroniser, change taken when stages two and three agree
`timescale 1ns/10ps
`default_nettype none
module ssp_sync3 #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_arst_n,
  // levels
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] s1_r;
  logic [W-1:0] s2_r;
  logic [W-1:0] s3_r;

  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s1_r <= '0;
      s2_r <= '0;
      s3_r <= '0;
      o_q  <= '0;
    end else begin
      s1_r <= i_d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      for (int i = 0; i < W; i++) begin
        if (s2_r[i] == s3_r[i]) begin
          o_q[i] <= s3_r[i];
        end
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/ssp_sensor.sv
// sensor end: serial slave on the link clock, power states on the oscillator
`timescale 1ns/10ps
`default_nettype none
`include "ssp_map.svh"
module ssp_sensor #(
  parameter logic [31:0] P_MOT_CYC   = `SSP_CYC_MS(`SSP_T_MOT_RST_MS),
  parameter logic [31:0] P_REST_CYC  = `SSP_CYC_S(`SSP_T_REST_S),
  parameter logic [31:0] P_PD_CYC    = `SSP_CYC_MS(`SSP_T_PD_MS),
  parameter logic [31:0] P_WAKE_CYC  = `SSP_CYC_MS(`SSP_T_WAKE_MS),
  parameter logic [31:0] P_QUIET_CYC = `SSP_CYC_MS(`SSP_T_QUIET_MS)
) (
  // oscillator and reset
  input  wire logic i_clk,
  input  wire logic i_arst_n,
  // link
  ssp_if.dev        link,
  // sensor state
  output logic       o_motion_valid,
  output logic       o_low_power,
  output logic [1:0] o_rest_state
);
  ssp_pkg::ssp_dev_state_t state_r;
  logic [31:0] cnt_r;
  logic [31:0] qcnt_r;
  logic        flush_r;
  logic        fired_r;
  logic        srst_n;
  logic [3:0]  bit_r;
  logic [14:0] rx_r;
  logic [7:0]  addr_r;
  logic [7:0]  tx_r;
  logic [7:0]  pc_r;
  logic        rst_tog_r;
  logic        act_tog_r;
  logic        oe_n_r;
  logic        sdo_r;
  logic [2:0]  stat_s;
  logic [4:0]  ctl_s;
  logic        rst_d_r;
  logic        act_d_r;
  logic        rst_ev;
  logic        act_ev;
  logic        pd_s;
  logic [1:0]  rm_s;
  logic [7:0]  in_byte;
  logic [1:0]  rm_d_r;
  logic [1:0]  rm_r;

  assign srst_n  = i_arst_n & ~flush_r;
  assign in_byte = {rx_r[6:0], link.sdio};
  assign link.dev_sdo      = sdo_r;
  assign link.dev_sdo_oe_n = oe_n_r;

  // serial shift engine, sampled on rising edges
  always_ff @(posedge link.sclk or negedge srst_n) begin
    if (!srst_n) begin
      bit_r     <= 4'h0;
      rx_r      <= 15'h0000;
      addr_r    <= 8'h00;
      tx_r      <= 8'h00;
      act_tog_r <= 1'b0;
    end else begin
      bit_r     <= bit_r + 4'h1;
      rx_r      <= {rx_r[13:0], link.sdio};
      act_tog_r <= ~act_tog_r;
      if (bit_r == 4'h7) begin
        addr_r <= in_byte;
        if (!in_byte[`SSP_DIR_BIT]) begin
          unique case (in_byte[6:0])
            `SSP_REG_PWR:  tx_r <= pc_r;
            `SSP_REG_STAT: tx_r <= {5'h00, stat_s};
            default:       tx_r <= 8'h00;
          endcase
        end
      end
    end
  end

  // register writes on the last data bit
  always_ff @(posedge link.sclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pc_r      <= `SSP_PWR_RESET;
      rst_tog_r <= 1'b0;
    end else if (bit_r == 4'hf && addr_r[`SSP_DIR_BIT]) begin
      if (addr_r[6:0] == `SSP_REG_PWR) begin
        pc_r <= in_byte;
      end else if (addr_r[6:0] == `SSP_REG_RST) begin
        pc_r      <= `SSP_PWR_RESET;
        rst_tog_r <= ~rst_tog_r;
      end
    end
  end

  // data out on falling edges; drive starts in a read data byte and holds until the next falling edge or flush
  always_ff @(negedge link.sclk or negedge srst_n) begin
    if (!srst_n) begin
      oe_n_r <= 1'b1;
      sdo_r  <= 1'b1;
    end else begin
      oe_n_r <= ~(bit_r[3] & ~addr_r[`SSP_DIR_BIT]);
      sdo_r  <= tx_r[~bit_r[2:0]];
    end
  end

  ssp_sync3 #(.W(3)) u_stat_sync (
    .i_clk    (link.sclk),
    .i_arst_n (i_arst_n),
    .i_d      ({o_rest_state != 2'b00, o_low_power, o_motion_valid}),
    .o_q      (stat_s)
  );

  ssp_sync3 #(.W(5)) u_ctl_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_d      ({pc_r[`SSP_RM_LO+1:`SSP_RM_LO], pc_r[`SSP_PD_BIT], act_tog_r, rst_tog_r}),
    .o_q      (ctl_s)
  );

  // rest bits cross as a pair: taken only once stable for two cycles
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rm_d_r <= 2'b00;
      rm_r   <= 2'b00;
    end else begin
      rm_d_r <= ctl_s[4:3];
      if (ctl_s[4:3] == rm_d_r) begin
        rm_r <= rm_d_r;
      end
    end
  end

  assign rm_s   = rm_r;
  assign pd_s   = ctl_s[2];
  assign act_ev = ctl_s[1] ^ act_d_r;
  assign rst_ev = ctl_s[0] ^ rst_d_r;

  // quiet link detection resets the serial engine
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      qcnt_r  <= 32'h0000_0000;
      flush_r <= 1'b0;
      fired_r <= 1'b0;
      act_d_r <= 1'b0;
    end else begin
      act_d_r <= ctl_s[1];
      flush_r <= 1'b0;
      if (act_ev) begin
        qcnt_r  <= 32'h0000_0000;
        fired_r <= 1'b0;
      end else if (qcnt_r == P_QUIET_CYC - 32'h0000_0001 && !fired_r) begin
        flush_r <= 1'b1;
        fired_r <= 1'b1;
      end else if (!fired_r) begin
        qcnt_r <= qcnt_r + 32'h0000_0001;
      end
    end
  end

  // power state machine
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r        <= ssp_pkg::D_RST_WAIT;
      cnt_r          <= P_MOT_CYC;
      rst_d_r        <= 1'b0;
      o_motion_valid <= 1'b0;
      o_low_power    <= 1'b0;
      o_rest_state   <= 2'b00;
    end else begin
      rst_d_r <= ctl_s[0];
      if (rst_ev) begin
        o_motion_valid <= 1'b0;
        o_low_power    <= 1'b0;
        o_rest_state   <= 2'b00;
        if (state_r == ssp_pkg::D_PD || state_r == ssp_pkg::D_PD_IN) begin
          state_r <= ssp_pkg::D_WAKE;
          cnt_r   <= P_WAKE_CYC;
        end else begin
          state_r <= ssp_pkg::D_RST_WAIT;
          cnt_r   <= P_MOT_CYC;
        end
      end else begin
        unique case (state_r)
          ssp_pkg::D_ACTIVE: begin
            if (pd_s) begin
              state_r        <= ssp_pkg::D_PD_IN;
              cnt_r          <= P_PD_CYC;
              o_motion_valid <= 1'b0;
            end else if (rm_s != 2'b00) begin
              state_r        <= ssp_pkg::D_REST_IN;
              cnt_r          <= P_REST_CYC;
              o_motion_valid <= 1'b0;
            end
          end
          ssp_pkg::D_RST_WAIT, ssp_pkg::D_WAKE, ssp_pkg::D_REST_OUT: begin
            if (cnt_r == 32'h0000_0000) begin
              state_r        <= ssp_pkg::D_ACTIVE;
              o_motion_valid <= 1'b1;
            end else begin
              cnt_r <= cnt_r - 32'h0000_0001;
            end
          end
          ssp_pkg::D_REST_IN: begin
            if (rm_s == 2'b00) begin
              state_r <= ssp_pkg::D_REST_OUT;
              cnt_r   <= P_REST_CYC;
            end else if (cnt_r == 32'h0000_0000) begin
              state_r      <= ssp_pkg::D_REST;
              o_rest_state <= rm_s;
            end else begin
              cnt_r <= cnt_r - 32'h0000_0001;
            end
          end
          ssp_pkg::D_REST: begin
            if (rm_s == 2'b00) begin
              state_r      <= ssp_pkg::D_REST_OUT;
              cnt_r        <= P_REST_CYC;
              o_rest_state <= 2'b00;
            end else if (pd_s) begin
              state_r      <= ssp_pkg::D_PD_IN;
              cnt_r        <= P_PD_CYC;
              o_rest_state <= 2'b00;
            end else begin
              o_rest_state <= rm_s;
            end
          end
          ssp_pkg::D_PD_IN: begin
            if (cnt_r == 32'h0000_0000) begin
              state_r     <= ssp_pkg::D_PD;
              o_low_power <= 1'b1;
            end else begin
              cnt_r <= cnt_r - 32'h0000_0001;
            end
          end
          ssp_pkg::D_PD: begin
            state_r <= ssp_pkg::D_PD;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// File: rtl/ssp_host.sv
// host end: APB command registers driving the two-wire serial link
//
// Overview of operation
// - valid motion within 50 ms of reset
// - forced rest reached within 1 s
// - rest cleared gives motion within 1 s
// - power-down bit reaches low current in 50 ms
// - reset register write wakes within 55 ms
// - failed transfer: 50 ms quiet resets port
// - 30 us between two writes' last bits
// - 20 us from write to read address end
// - 250 ns after read before next command
// - 4 us turnaround before read data
// - above 500 dpi use 12-bit motion
// - write: address byte msb one, then data
// - read: address msb zero, sensor returns data
// - sample on rising, change on falling edge
// - serial clock at most 1 MHz, half duty
`timescale 1ns/10ps
`default_nettype none
`include "ssp_map.svh"
module ssp_host #(
  parameter logic [31:0] P_WAKE_CYC  = `SSP_CYC_MS(`SSP_T_WAKE_MS),
  parameter logic [31:0] P_REST_CYC  = `SSP_CYC_S(`SSP_T_REST_S),
  parameter logic [31:0] P_QUIET_CYC = `SSP_CYC_MS(`SSP_T_QUIET_MS)
) (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_arst_n,
  // apb slave
  input  wire logic        i_psel,
  input  wire logic        i_penable,
  input  wire logic        i_pwrite,
  input  wire logic [7:0]  i_paddr,
  input  wire logic [31:0] i_pwdata,
  output logic      [31:0] o_prdata,
  output logic             o_pready,
  output logic             o_pslverr,
  // link
  ssp_if.host              link
);
  localparam logic [31:0] HALF = `SSP_HALF_CYC;
  localparam logic [31:0] WW   = `SSP_CYC_US(`SSP_T_WW_US);
  localparam logic [31:0] WR   = `SSP_CYC_US(`SSP_T_WR_US);
  localparam logic [31:0] RR   = `SSP_CYC_NS_UP(`SSP_T_RR_NS);
  localparam logic [31:0] SRAD = `SSP_CYC_US(`SSP_T_SRAD_US);

  ssp_pkg::ssp_host_state_t state_r;
  logic [31:0] cnt_r;
  logic [3:0]  bit_r;
  logic [15:0] sh_r;
  logic [7:0]  rx_r;
  logic [7:0]  rd_data_r;
  logic [1:0]  rm_r;
  logic        wr_r;
  logic        last_wr_r;
  logic [11:0] gap_r;
  logic        sclk_r;
  logic        sdo_r;
  logic        oe_n_r;
  logic        sdi_s;
  logic        busy;
  logic        acc;
  logic        fire;
  logic        cmd_go;
  logic        last_rise;
  logic [31:0] high_lim;

  // least spacing from the previous transfer's last rising edge
  function automatic logic [31:0] gap_need(input logic prev_wr, input logic next_wr);
    return prev_wr ? (next_wr ? WW : WR) : RR;
  endfunction

  assign link.sclk          = sclk_r;
  assign link.host_sdo      = sdo_r;
  assign link.host_sdo_oe_n = oe_n_r;

  ssp_sync3 #(.W(1)) u_sdi_sync (
    .i_clk    (i_clk),
    .i_arst_n (i_arst_n),
    .i_d      (link.sdio),
    .o_q      (sdi_s)
  );

  assign busy      = (state_r != ssp_pkg::H_IDLE);
  assign acc       = i_psel & i_penable & ~o_pready;
  assign fire      = i_psel & i_penable & o_pready & i_pwrite;
  assign cmd_go    = fire & (i_paddr == `SSP_APB_CMD) & ~busy;
  assign last_rise = (state_r == ssp_pkg::H_LOW) && (cnt_r == HALF - 32'h0000_0001)
                     && (bit_r == 4'hf);
  assign high_lim  = (!wr_r && bit_r == 4'h7) ? SRAD - 32'h0000_0001
                                              : HALF - 32'h0000_0001;

  // apb answer with one wait state
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready <= acc;
      if (acc) begin
        o_pslverr <= 1'b0;
        o_prdata  <= 32'h0000_0000;
        if (i_paddr == `SSP_APB_STAT && !i_pwrite) begin
          o_prdata <= {16'h0000, rd_data_r, 6'h00, state_r == ssp_pkg::H_HOLD, busy};
        end else if (i_paddr == `SSP_APB_CMD && i_pwrite) begin
          o_pslverr <= busy;
        end else begin
          o_pslverr <= 1'b1;
        end
      end else begin
        o_pslverr <= 1'b0;
      end
    end
  end

  // time since the last rising edge of the previous transfer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      gap_r     <= 12'hfff;
      last_wr_r <= 1'b0;
    end else if (last_rise) begin
      gap_r     <= 12'h000;
      last_wr_r <= wr_r;
    end else if (gap_r != 12'hfff) begin
      gap_r <= gap_r + 12'h001;
    end
  end

  // transfer sequencer
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state_r   <= ssp_pkg::H_IDLE;
      cnt_r     <= 32'h0000_0000;
      bit_r     <= 4'h0;
      sh_r      <= 16'h0000;
      rx_r      <= 8'h00;
      rd_data_r <= 8'h00;
      rm_r      <= 2'b00;
      wr_r      <= 1'b0;
      sclk_r    <= 1'b1;
      sdo_r     <= 1'b1;
      oe_n_r    <= 1'b1;
    end else begin
      unique case (state_r)
        ssp_pkg::H_IDLE: begin
          if (cmd_go) begin
            if (i_pwdata[`SSP_CMD_REC_BIT]) begin
              state_r <= ssp_pkg::H_HOLD;
              cnt_r   <= P_QUIET_CYC;
            end else begin
              sh_r    <= {i_pwdata[`SSP_CMD_WR_BIT], i_pwdata[14:0]};
              wr_r    <= i_pwdata[`SSP_CMD_WR_BIT];
              state_r <= ssp_pkg::H_GAP;
            end
          end
        end
        ssp_pkg::H_GAP: begin
          if ({20'h0_0000, gap_r} >= gap_need(last_wr_r, wr_r)) begin
            sclk_r  <= 1'b0;
            sdo_r   <= sh_r[15];
            oe_n_r  <= 1'b0;
            cnt_r   <= 32'h0000_0000;
            bit_r   <= 4'h0;
            state_r <= ssp_pkg::H_LOW;
          end
        end
        ssp_pkg::H_LOW: begin
          if (cnt_r == HALF - 32'h0000_0001) begin
            sclk_r  <= 1'b1;
            cnt_r   <= 32'h0000_0000;
            state_r <= ssp_pkg::H_HIGH;
            if (!wr_r && bit_r[3]) begin
              rx_r <= {rx_r[6:0], sdi_s};
            end
          end else begin
            cnt_r <= cnt_r + 32'h0000_0001;
          end
        end
        ssp_pkg::H_HIGH: begin
          // release one cycle after the rise, so the last address bit is sampled intact
          if (!wr_r && bit_r == 4'h7 && cnt_r == 32'h0000_0000) begin
            oe_n_r <= 1'b1;
          end
          if (cnt_r == high_lim) begin
            cnt_r <= 32'h0000_0000;
            if (bit_r == 4'hf) begin
              oe_n_r  <= 1'b1;
              state_r <= ssp_pkg::H_IDLE;
              if (!wr_r) begin
                rd_data_r <= rx_r;
              end else if (sh_r[14:8] == `SSP_REG_RST) begin
                rm_r    <= 2'b00;
                state_r <= ssp_pkg::H_HOLD;
                cnt_r   <= P_WAKE_CYC;
              end else if (sh_r[14:8] == `SSP_REG_PWR
                           && sh_r[`SSP_RM_LO+1:`SSP_RM_LO] != rm_r) begin
                rm_r    <= sh_r[`SSP_RM_LO+1:`SSP_RM_LO];
                state_r <= ssp_pkg::H_HOLD;
                cnt_r   <= P_REST_CYC;
              end
            end else begin
              bit_r   <= bit_r + 4'h1;
              sdo_r   <= sh_r[4'he - bit_r];
              sclk_r  <= 1'b0;
              state_r <= ssp_pkg::H_LOW;
            end
          end else begin
            cnt_r <= cnt_r + 32'h0000_0001;
          end
        end
        ssp_pkg::H_HOLD: begin
          if (cnt_r == 32'h0000_0000) begin
            state_r <= ssp_pkg::H_IDLE;
          end else begin
            cnt_r <= cnt_r - 32'h0000_0001;
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// File: dv/ssp_link_checker.sv
// assertions on the two-wire link between host and sensor
`timescale 1ns/10ps
`default_nettype none
module ssp_link_checker (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_arst_n,
  // link signals
  input wire logic sclk,
  input wire logic host_sdo,
  input wire logic host_sdo_oe_n,
  input wire logic dev_sdo,
  input wire logic dev_sdo_oe_n,
  input wire logic sdio
);
  logic [31:0] lo_cnt;
  logic [31:0] hi_cnt;
  logic [31:0] gap_cnt;
  logic [3:0]  bcnt;
  logic        dir_r;
  logic        prev_wr;

  // cycles sclk has been low or high
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      lo_cnt <= 32'h0000_0000;
      hi_cnt <= 32'h0000_0000;
    end else begin
      lo_cnt <= sclk ? 32'h0000_0000 : lo_cnt + 32'h0000_0001;
      hi_cnt <= sclk ? hi_cnt + 32'h0000_0001 : 32'h0000_0000;
    end
  end

  // bit position in frame, direction, time since last frame end
  always_ff @(posedge i_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      bcnt    <= 4'h0;
      dir_r   <= 1'b1;
      prev_wr <= 1'b0;
      gap_cnt <= 32'h0000_0000;
    end else begin
      if ($rose(sclk)) bcnt <= bcnt + 4'h1;
      if ($rose(sclk) && bcnt == 4'h0) dir_r <= sdio;
      if ($rose(sclk) && bcnt == 4'hf) begin
        prev_wr <= dir_r;
        gap_cnt <= 32'h0000_0000;
      end else begin
        gap_cnt <= gap_cnt + 32'h0000_0001;
      end
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_arst_n);

  chk_sclk_low_half: assert property ($rose(sclk) |-> lo_cnt == 32'd50)
    else $error("sclk low phase not 50 cycles");
  chk_sclk_high_min: assert property ($fell(sclk) |-> hi_cnt >= 32'd50)
    else $error("sclk high phase too short");
  chk_host_edge_fall: assert property
    ($changed(host_sdo) && !host_sdo_oe_n && !$past(host_sdo_oe_n) |-> $fell(sclk))
    else $error("host data changed off the falling edge");
  chk_dev_edge_fall: assert property
    ($changed(dev_sdo) && !dev_sdo_oe_n && !$past(dev_sdo_oe_n) |-> !sclk)
    else $error("sensor data changed while sclk high");
  chk_no_contention: assert property (host_sdo_oe_n || dev_sdo_oe_n)
    else $error("both ends drive the data line");
  chk_wr_host_drive: assert property
    ($rose(sclk) && bcnt != 4'h0 && dir_r |-> !host_sdo_oe_n && dev_sdo_oe_n)
    else $error("write bit not driven by host alone");
  chk_rd_dev_drive: assert property
    ($rose(sclk) && bcnt >= 4'h8 && !dir_r |-> host_sdo_oe_n && !dev_sdo_oe_n)
    else $error("read data bit not driven by sensor alone");
  chk_rd_turnaround: assert property
    ($fell(sclk) && bcnt == 4'h8 && !dir_r |-> hi_cnt >= 32'd400)
    else $error("read turnaround below 400 cycles");
  chk_rd_next_gap: assert property ($fell(sclk) && bcnt == 4'h0 && !dir_r |-> hi_cnt >= 32'd25)
    else $error("command too soon after read");
  chk_ww_gap: assert property
    ($rose(sclk) && bcnt == 4'hf && dir_r && prev_wr |-> gap_cnt >= 32'd3000)
    else $error("write to write gap below 3000 cycles");
  chk_wr_gap: assert property
    ($rose(sclk) && bcnt == 4'h7 && !dir_r && prev_wr |-> gap_cnt >= 32'd2000)
    else $error("write to read gap below 2000 cycles");

  cov_write: cover property ($rose(sclk) && bcnt == 4'hf && dir_r);
  cov_read: cover property ($rose(sclk) && bcnt == 4'hf && !dir_r);
  cov_ww: cover property ($rose(sclk) && bcnt == 4'hf && dir_r && prev_wr);
endmodule
`default_nettype wire

// File: dv/tb.sv
// self-checking bench: host and sensor joined by the link
`timescale 1ns/10ps
`default_nettype none
`include "ssp_map.svh"
module tb;
  localparam logic [31:0] P_MOT   = 32'h0000_0190;
  localparam logic [31:0] P_REST  = 32'h0000_0258;
  localparam logic [31:0] P_PD    = 32'h0000_012c;
  localparam logic [31:0] P_WAKE  = 32'h0000_01f4;
  localparam logic [31:0] P_QUIET = 32'h0000_03e8;
  logic        i_clk, osc_clk, i_arst_n, psel, penable, pwrite, pready, pslverr, mv, lp;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  rs;
  int          n_errors, tests_run, seed;

  ssp_if link();
  ssp_host #(.P_WAKE_CYC(P_WAKE), .P_REST_CYC(P_REST), .P_QUIET_CYC(P_QUIET)) ssp_host_i (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite),
    .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .link(link));
  ssp_sensor #(.P_MOT_CYC(P_MOT), .P_REST_CYC(P_REST), .P_PD_CYC(P_PD), .P_WAKE_CYC(P_WAKE),
    .P_QUIET_CYC(P_QUIET)) ssp_sensor_i (
    .i_clk(osc_clk), .i_arst_n(i_arst_n), .link(link), .o_motion_valid(mv),
    .o_low_power(lp), .o_rest_state(rs));
  ssp_link_checker chk_i (
    .i_clk(i_clk), .i_arst_n(i_arst_n), .sclk(link.sclk), .host_sdo(link.host_sdo),
    .host_sdo_oe_n(link.host_sdo_oe_n), .dev_sdo(link.dev_sdo),
    .dev_sdo_oe_n(link.dev_sdo_oe_n), .sdio(link.sdio));

  initial begin
    i_clk = 1'b0;
    forever #5 i_clk = ~i_clk;
  end
  // sensor oscillator, phase unrelated to the host clock
  initial begin
    osc_clk = 1'b0;
    #3;
    forever #5 osc_clk = ~osc_clk;
  end

  task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    @(posedge i_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge i_clk);
    penable <= 1'b1;
    do begin
      @(posedge i_clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) begin
      n_errors++;
      end_sim();
    end
  endtask

  task automatic wait_idle;
    logic [31:0] r;
    logic        e;
    int          n;
    for (n = 0; n < 5000; n++) begin
      apb(1'b0, `SSP_APB_STAT, 32'h0000_0000, r, e);
      if (r[1:0] === 2'b00) break;
    end
    if (n >= 5000) begin
      n_errors++;
      end_sim();
    end
  endtask

  // one serial transfer; returns the byte read back
  task automatic sx(input logic wr, input logic [6:0] a, input logic [7:0] d,
                    output logic [7:0] q);
    logic [31:0] r;
    logic        e;
    apb(1'b1, `SSP_APB_CMD, {16'h0000, wr, a, d}, r, e);
    check("cmd_accept", 32'h0000_0000, {31'h0, e});
    wait_idle();
    apb(1'b0, `SSP_APB_STAT, 32'h0000_0000, r, e);
    q = r[15:8];
  endtask

  // wait bounded for masked {rest, low power, motion valid}
  task automatic wait_out(input logic [3:0] m, input logic [3:0] exp, input int lim,
                          input string nm);
    int n;
    for (n = 0; n < lim; n++) begin
      @(posedge i_clk);
      if (({rs, lp, mv} & m) === exp) break;
    end
    check(nm, {28'h0, exp}, {28'h0, {rs, lp, mv} & m});
    if (n >= lim) end_sim();
  endtask

  initial begin
    logic [31:0] r;
    logic        e;
    logic [7:0]  d, q;
    int          i, bad;
    seed = 32'h9cde;
    n_errors = 0;
    tests_run = 0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    i_arst_n = 1'b0;
    repeat (6) @(posedge i_clk);
    i_arst_n <= 1'b1;
    wait_out(4'hf, 4'h1, P_MOT + 20, "motion_after_reset");
    apb(1'b0, 8'h08, 32'h0000_0000, r, e);
    check("unmapped_err", 32'h1, {31'h0, e});
    check("unmapped_data", 32'h0, r);
    apb(1'b1, `SSP_APB_CMD, 32'h0000_8d00, r, e);
    apb(1'b1, `SSP_APB_CMD, 32'h0000_8d00, r, e);
    check("busy_refuse", 32'h1, {31'h0, e});
    wait_idle();
    for (i = 0; i < 5; i++) begin
      d = (i == 0) ? 8'hf1 : (i == 1) ? 8'h00 : 8'($random(seed)) & 8'hf1;
      sx(1'b1, `SSP_REG_PWR, d, q);
      sx(1'b0, `SSP_REG_PWR, 8'h00, q);
      check("pwr_readback", {24'h0, d}, {24'h0, q});
    end
    sx(1'b0, 7'h55, 8'h00, q);
    check("unknown_reg", 32'h0, {24'h0, q});
    sx(1'b0, `SSP_REG_STAT, 8'h00, q);
    check("status_reg", 32'h1, {24'h0, q});
    for (i = 1; i < 4; i++) begin
      sx(1'b1, `SSP_REG_PWR, {4'h0, 2'(i), 2'b00}, q);
      wait_out(4'hc, {2'(i), 2'b00}, P_REST, "rest_enter");
      sx(1'b1, `SSP_REG_PWR, 8'h00, q);
      wait_out(4'hd, 4'h1, P_REST, "rest_exit");
    end
    sx(1'b1, `SSP_REG_PWR, 8'h02, q);
    wait_out(4'h2, 4'h2, P_PD + 2000, "pd_enter");
    sx(1'b1, `SSP_REG_RST, 8'($random(seed)), q);
    wait_out(4'h3, 4'h1, P_WAKE + 2000, "wake");
    sx(1'b0, `SSP_REG_PWR, 8'h00, q);
    check("pwr_cleared", 32'h0, {24'h0, q});
    apb(1'b1, `SSP_APB_CMD, 32'h0001_0000, r, e);
    bad = 0;
    for (i = 0; i < 900; i++) begin
      @(posedge i_clk);
      if (link.sclk !== 1'b1) bad++;
    end
    check("quiet_sclk", 32'h0, 32'(bad));
    wait_idle();
    check("quiet_release", 32'h1, {31'h0, link.dev_sdo_oe_n});
    sx(1'b0, `SSP_REG_STAT, 8'h00, q);
    check("status_after_quiet", 32'h1, {24'h0, q});
    end_sim();
  end
endmodule
`default_nettype wire
